// ### loop_ctrl_pkg.sv
package loop_ctrl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] EVEN_LOOP_OFS = 12'h040;
  localparam logic [11:0] WCRUSH_OFS = 12'h044;
  localparam logic [11:0] ODD_LOOP_OFS = 12'h0C0;
  localparam logic [11:0] STATUS_OFS = 12'h0C4;
  localparam logic [11:0] SCALE_OFS = 12'h0C8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [7:0] WCRUSH_RST = 8'hCF;
  localparam logic [7:0] SCALE_RST = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PEAK_BIT = 7;
  localparam int CGAIN_BIT = 6;
  localparam int LOWCOL_BIT = 5;
  localparam int HF_HI = 4;
  localparam int HF_LO = 3;
  localparam int MAJ_HI = 7;
  localparam int MAJ_LO = 6;
  localparam int STEP_HI = 5;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] HF_AUTO = 2'h0;
  localparam logic [1:0] HF_PK_MAX_FULL = 2'h1;
  localparam logic [1:0] HF_PK_MIN_HALF = 2'h2;
  localparam logic [1:0] MAJ_3Q = 2'h0;
  localparam logic [1:0] MAJ_HALF = 2'h1;
  localparam logic [1:0] MAJ_1Q = 2'h2;

  // Scale ratio thresholds, 8-bit ratio where 0x80 is one half
  localparam logic [7:0] RATIO_HALF = 8'h80;
  localparam logic [7:0] RATIO_QUARTER = 8'h40;
  localparam logic [7:0] RATIO_EIGHTH = 8'h20;

  // Chroma gain bounds, 2.6 fixed point: 0.5 and 2.0
  localparam logic [7:0] CGAIN_MIN = 8'h20;
  localparam logic [7:0] CGAIN_MAX = 8'h80;
  localparam logic [7:0] CGAIN_UNITY = 8'h40;

  // Luma comparison levels for 8-bit luma
  localparam logic [7:0] LUMA_3Q = 8'hC0;
  localparam logic [7:0] LUMA_HALF = 8'h80;
  localparam logic [7:0] LUMA_1Q = 8'h40;

  // ----------------------------------------
  // Filter selections
  // ----------------------------------------
  typedef enum logic [2:0] {
    FILT_NONE,
    FILT_HALF,
    FILT_QUARTER,
    FILT_EIGHTH,
    FILT_PK_MIN_FULL,
    FILT_PK_MAX_FULL,
    FILT_PK_MIN_HALF
  } filt_sel_t;

  // Auto filter from horizontal scaling ratio
  function automatic filt_sel_t auto_filter(input logic [7:0] ratio);
    if (ratio > RATIO_HALF) begin
      auto_filter = FILT_NONE;
    end else if (ratio > RATIO_QUARTER) begin
      auto_filter = FILT_HALF;
    end else if (ratio > RATIO_EIGHTH) begin
      auto_filter = FILT_QUARTER;
    end else begin
      auto_filter = FILT_EIGHTH;
    end
  endfunction

endpackage

// ### wcrush_accum.sv
`timescale 1ns/1ps
module wcrush_accum
#(
  parameter int ACC_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [1:0] majority_point_select_i,
  input wire logic [5:0] white_crush_step_i,
  input wire logic [7:0] auto_level_i,
  // Pixel stream
  input wire logic pix_valid_i,
  input wire logic [7:0] luma_i,
  input wire logic field_end_i,
  // Result
  output logic [ACC_W-1:0] accum_o
);

  import loop_ctrl_pkg::*;

  // ----------------------------------------
  // Majority vote over one field
  // ----------------------------------------
  logic [7:0] level;
  logic signed [23:0] vote_q;

  // Comparison point from the majority select field
  always_comb begin
    case (majority_point_select_i)
      MAJ_3Q: level = LUMA_3Q;
      MAJ_HALF: level = LUMA_HALF;
      MAJ_1Q: level = LUMA_1Q;
      default: level = auto_level_i;
    endcase
  end

  // Votes: below the point counts up, else down
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || field_end_i) begin
      vote_q <= '0;
    end else if (pix_valid_i) begin
      vote_q <= (luma_i < level) ? vote_q + 24'sd1 : vote_q - 24'sd1;
    end
  end

  // Step added at field end when the vote is positive, saturating, unsigned
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      accum_o <= '0;
    end else if (field_end_i && vote_q > 24'sd0) begin
      if (accum_o > {ACC_W{1'b1}} - ACC_W'(white_crush_step_i)) begin
        accum_o <= {ACC_W{1'b1}};
      end else begin
        accum_o <= accum_o + ACC_W'(white_crush_step_i);
      end
    end
  end

endmodule // wcrush_accum

// ### luma_chroma_loop_control.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module luma_chroma_loop_control
#(
  parameter int ACC_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Video timing and data
  input wire logic odd_field_i,
  input wire logic field_end_i,
  input wire logic pix_valid_i,
  input wire logic [7:0] luma_i,
  input wire logic [7:0] chroma_level_i,
  input wire logic [7:0] base_agc_i,
  input wire logic luma_decimation_control_i,
  // Control outputs
  output loop_ctrl_pkg::filt_sel_t filter_sel_o,
  output logic chroma_gain_loop_enable_o,
  output logic [7:0] chroma_gain_o,
  output logic low_color_removal_enable_o,
  output logic [1:0] horiz_filter_select_o,
  output logic [8:0] agc_value_o,
  output logic filter_ok_o
);

  import loop_ctrl_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] even_loop_q;
  logic [7:0] odd_loop_q;
  logic [7:0] wcrush_q;
  logic [7:0] scale_q;
  logic [7:0] active;
  logic [ACC_W-1:0] accum;
  logic wr_en;
  logic rd_en;

  assign wr_en = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd_en = cyc_i && stb_i && !ack_o;

  // Acknowledge one cycle after request, dropped next cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Even and odd loop control copies
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      even_loop_q <= LOOP_RST;
      odd_loop_q <= LOOP_RST;
    end else if (wr_en && adr_i == EVEN_LOOP_OFS) begin
      even_loop_q <= dat_i[7:0];
    end else if (wr_en && adr_i == ODD_LOOP_OFS) begin
      odd_loop_q <= dat_i[7:0];
    end
  end

  // White crush register, writable any time
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wcrush_q <= WCRUSH_RST;
    end else if (wr_en && adr_i == WCRUSH_OFS) begin
      wcrush_q <= dat_i[7:0];
    end
  end

  // Horizontal scaling ratio for auto filtering
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scale_q <= SCALE_RST;
    end else if (wr_en && adr_i == SCALE_OFS) begin
      scale_q <= dat_i[7:0];
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dat_o <= '0;
    end else if (rd_en) begin
      case (adr_i)
        EVEN_LOOP_OFS: dat_o <= {24'h000000, even_loop_q};
        WCRUSH_OFS: dat_o <= {24'h000000, wcrush_q};
        ODD_LOOP_OFS: dat_o <= {24'h000000, odd_loop_q};
        SCALE_OFS: dat_o <= {24'h000000, scale_q};
        STATUS_OFS: dat_o <= {13'h0000, filter_ok_o, filter_sel_o, 7'h00, accum[ACC_W-1:4]};
        default: dat_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Field copy selection
  // ----------------------------------------
  assign active = odd_field_i ? odd_loop_q : even_loop_q;

  // Plain enables and field
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      chroma_gain_loop_enable_o <= 1'b0;
      low_color_removal_enable_o <= 1'b0;
      horiz_filter_select_o <= HF_AUTO;
      filter_ok_o <= 1'b0;
    end else begin
      chroma_gain_loop_enable_o <= active[CGAIN_BIT];
      low_color_removal_enable_o <= active[LOWCOL_BIT];
      horiz_filter_select_o <= active[HF_HI:HF_LO];
      filter_ok_o <= !luma_decimation_control_i;
    end
  end

  // ----------------------------------------
  // Filter selection
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      filter_sel_o <= FILT_NONE;
    end else if (active[PEAK_BIT]) begin
      case (active[HF_HI:HF_LO])
        HF_PK_MAX_FULL: filter_sel_o <= FILT_PK_MAX_FULL;
        HF_PK_MIN_HALF: filter_sel_o <= FILT_PK_MIN_HALF;
        default: filter_sel_o <= FILT_PK_MIN_FULL;
      endcase
    end else if (active[HF_HI:HF_LO] == HF_AUTO) begin
      filter_sel_o <= auto_filter(scale_q);
    end else begin
      filter_sel_o <= filt_sel_t'({1'b0, active[HF_HI:HF_LO]});
    end
  end

  // ----------------------------------------
  // Chroma gain loop
  // ----------------------------------------
  // Gain nudged toward nominal chroma level, clamped 0.5 to 2.0
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      chroma_gain_o <= CGAIN_UNITY;
    end else if (!active[CGAIN_BIT]) begin
      chroma_gain_o <= CGAIN_UNITY;
    end else if (field_end_i) begin
      if (chroma_level_i < LUMA_HALF && chroma_gain_o < CGAIN_MAX) begin
        chroma_gain_o <= chroma_gain_o + 8'h01;
      end else if (chroma_level_i > LUMA_HALF && chroma_gain_o > CGAIN_MIN) begin
        chroma_gain_o <= chroma_gain_o - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // White crush up
  // ----------------------------------------
  wcrush_accum #(
    .ACC_W(ACC_W)
  ) u_accum (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .majority_point_select_i(wcrush_q[MAJ_HI:MAJ_LO]),
    .white_crush_step_i(wcrush_q[STEP_HI:0]),
    .auto_level_i(base_agc_i),
    .pix_valid_i(pix_valid_i),
    .luma_i(luma_i),
    .field_end_i(field_end_i),
    .accum_o(accum)
  );

  // AGC raised by accumulated value, saturating
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      agc_value_o <= '0;
    end else if ({1'b0, base_agc_i} + accum[ACC_W-1:4] > 9'h1FF) begin
      agc_value_o <= 9'h1FF;
    end else begin
      agc_value_o <= 9'({1'b0, base_agc_i} + accum[ACC_W-1:4]);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_peak_sel;
    @(posedge mclk_i) disable iff (!rst_n_i)
      active[PEAK_BIT] |=> filter_sel_o inside {FILT_PK_MIN_FULL, FILT_PK_MAX_FULL,
        FILT_PK_MIN_HALF};
  endproperty
  a_peak_sel: assert property (p_peak_sel) else $error("peak filter not chosen");

  property p_gain_range;
    @(posedge mclk_i) disable iff (!rst_n_i)
      chroma_gain_o >= CGAIN_MIN && chroma_gain_o <= CGAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("chroma gain out of range");

  property p_lowcol;
    @(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> low_color_removal_enable_o == $past(active[LOWCOL_BIT]);
  endproperty
  a_lowcol: assert property (p_lowcol) else $error("low colour enable wrong");

  property p_auto_none;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !active[PEAK_BIT] && active[HF_HI:HF_LO] == HF_AUTO && scale_q > RATIO_HALF
      |=> filter_sel_o == FILT_NONE;
  endproperty
  a_auto_none: assert property (p_auto_none) else $error("auto filter wrong");

  property p_pk_max;
    @(posedge mclk_i) disable iff (!rst_n_i)
      active[PEAK_BIT] && active[HF_HI:HF_LO] == HF_PK_MAX_FULL
      |=> filter_sel_o == FILT_PK_MAX_FULL;
  endproperty
  a_pk_max: assert property (p_pk_max) else $error("peaking select wrong");

  property p_wc_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_en && adr_i == WCRUSH_OFS |=> wcrush_q == $past(dat_i[7:0]);
  endproperty
  a_wc_write: assert property (p_wc_write) else $error("white crush write lost");

  property p_field_copy;
    @(posedge mclk_i) disable iff (!rst_n_i)
      odd_field_i |=> chroma_gain_loop_enable_o == $past(odd_loop_q[CGAIN_BIT]);
  endproperty
  a_field_copy: assert property (p_field_copy) else $error("wrong field copy");

  property p_accum_step;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !field_end_i |=> accum == $past(accum);
  endproperty
  a_accum_step: assert property (p_accum_step) else $error("accumulator moved midfield");

  property p_ack_pulse;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  // Filter field passed on one cycle later
  property p_hf_field;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i |=> horiz_filter_select_o == $past(active[HF_HI:HF_LO]);
  endproperty
  a_hf_field: assert property (p_hf_field) else $error("filter field not passed on");

  // Slowest scaling picks the eighth filter
  property p_auto_eighth;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i && !active[PEAK_BIT] && active[HF_HI:HF_LO] == HF_AUTO && scale_q <= RATIO_EIGHTH
      |=> filter_sel_o == FILT_EIGHTH;
  endproperty
  a_auto_eighth: assert property (p_auto_eighth) else $error("eighth filter not chosen");

  // Peaking code 10 picks minimum half peaking
  property p_pk_min_half;
    @(posedge mclk_i) disable iff (!rst_n_i)
      active[PEAK_BIT] && active[HF_HI:HF_LO] == HF_PK_MIN_HALF
      |=> filter_sel_o == FILT_PK_MIN_HALF;
  endproperty
  a_pk_min_half: assert property (p_pk_min_half) else $error("half peaking wrong");

  // Even field follows the even copy
  property p_even_copy;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i && !odd_field_i |=> chroma_gain_loop_enable_o == $past(even_loop_q[CGAIN_BIT]);
  endproperty
  a_even_copy: assert property (p_even_copy) else $error("wrong even copy");

  // AGC is base plus accumulated crush value
  property p_agc_sum;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i |=> agc_value_o == 9'($past(base_agc_i)) + 9'($past(accum[ACC_W-1:4]));
  endproperty
  a_agc_sum: assert property (p_agc_sum) else $error("agc value wrong");

  // Unsigned step never lowers the accumulator
  property p_accum_rise;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i |=> accum >= $past(accum);
  endproperty
  a_accum_rise: assert property (p_accum_rise) else $error("accumulator went down");

  c_peak: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    filter_sel_o == FILT_PK_MIN_HALF);
  c_eighth: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    filter_sel_o == FILT_EIGHTH);
  c_accum: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    field_end_i ##1 accum != $past(accum));
  c_odd_copy: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    odd_field_i ##1 low_color_removal_enable_o);
  c_gain_moved: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    chroma_gain_o != CGAIN_UNITY);

endmodule // luma_chroma_loop_control

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import loop_ctrl_pkg::*;

  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic mclk, rst_n, cyc, stb, we, odd_field, field_end, pix_valid, luma_decimation_control;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd;
  logic [7:0] luma, chroma_level, base_agc;
  wire logic [31:0] dat_o;
  wire logic ack_o, cg_en_o, lowcol_o, fok_o;
  wire logic [7:0] gain_o;
  wire logic [1:0] hf_o;
  wire logic [8:0] agc_o;
  filt_sel_t fsel_o;
  int mismatches = 0;
  int n_compared = 0;

  // Compare and count
  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  luma_chroma_loop_control #(.ACC_W(12)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .odd_field_i(odd_field),
    .field_end_i(field_end), .pix_valid_i(pix_valid), .luma_i(luma),
    .chroma_level_i(chroma_level), .base_agc_i(base_agc), .luma_decimation_control_i(luma_decimation_control),
    .filter_sel_o(fsel_o), .chroma_gain_loop_enable_o(cg_en_o), .chroma_gain_o(gain_o),
    .low_color_removal_enable_o(lowcol_o), .horiz_filter_select_o(hf_o), .agc_value_o(agc_o),
    .filter_ok_o(fok_o));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One classic Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d}; sel <= 4'hF;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge mclk);
  endtask

  // One field of pixels at a single luma level
  task automatic field(input logic [7:0] l);
    pix_valid <= 1'b1; luma <= l;
    step(16);
    pix_valid <= 1'b0; field_end <= 1'b1;
    step(1);
    field_end <= 1'b0;
    step(3);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    wb(1'b0, EVEN_LOOP_OFS, 8'h00); `CHK(rd, 32'h00000000)
    wb(1'b0, WCRUSH_OFS, 8'h00); `CHK(rd, 32'h000000CF)
    wb(1'b0, ODD_LOOP_OFS, 8'h00); `CHK(rd, 32'h00000000)
    wb(1'b1, 12'h100, 8'h5A);
    wb(1'b0, 12'h100, 8'h00); `CHK(rd, 32'h00000000)
    wb(1'b1, WCRUSH_OFS, 8'h96);
    wb(1'b0, WCRUSH_OFS, 8'h00); `CHK(rd, 32'h00000096)
  endtask

  // Even and odd copies steer the outputs by field
  task automatic t_field_copies();
    wb(1'b1, EVEN_LOOP_OFS, 8'hC8);
    wb(1'b1, ODD_LOOP_OFS, 8'h30);
    odd_field <= 1'b0; step(3);
    `CHK(fsel_o, FILT_PK_MAX_FULL)
    `CHK({cg_en_o, lowcol_o, hf_o}, 4'h9)
    odd_field <= 1'b1; step(3);
    `CHK(fsel_o, FILT_QUARTER)
    `CHK({cg_en_o, lowcol_o, hf_o}, 4'h6)
    odd_field <= 1'b0;
  endtask

  // Peaking table, then auto filter by scale ratio
  task automatic t_filters();
    logic [7:0] ratio [6];
    filt_sel_t fexp [6];
    filt_sel_t pk [3];
    ratio = '{8'h81, 8'h80, 8'h41, 8'h40, 8'h21, 8'h20};
    fexp = '{FILT_NONE, FILT_HALF, FILT_HALF, FILT_QUARTER, FILT_QUARTER, FILT_EIGHTH};
    pk = '{FILT_PK_MIN_FULL, FILT_PK_MAX_FULL, FILT_PK_MIN_HALF};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, EVEN_LOOP_OFS, 8'h80 | 8'(i << 3));
      step(2); `CHK(fsel_o, pk[i])
    end
    wb(1'b1, EVEN_LOOP_OFS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, SCALE_OFS, ratio[i]);
      step(2); `CHK(fsel_o, fexp[i])
    end
    `CHK(fok_o, 1'b1)
    luma_decimation_control <= 1'b1; step(3);
    `CHK(fok_o, 1'b0)
    luma_decimation_control <= 1'b0; step(2);
  endtask

  // White crush accumulation for every majority point
  task automatic t_white_crush();
    logic [7:0] dark [4];
    logic [7:0] bright [4];
    int acc;
    dark = '{8'hB0, 8'h70, 8'h30, 8'h08};
    bright = '{8'hD0, 8'h90, 8'h50, 8'h30};
    acc = 0;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, WCRUSH_OFS, 8'(m << 6) | 8'h3F);
      field(dark[m]);
      acc += 63;
      `CHK(agc_o, 9'(base_agc) + 9'(acc >> 4))
      field(bright[m]);
      `CHK(agc_o, 9'(base_agc) + 9'(acc >> 4))
    end
    wb(1'b0, STATUS_OFS, 8'h00); `CHK(rd[7:0], 8'(acc >> 4))
    wb(1'b1, WCRUSH_OFS, 8'h00);
    field(8'h08);
    `CHK(agc_o, 9'(base_agc) + 9'(acc >> 4))
  endtask

  // Chroma gain loop stays within bounds when on, unity when off
  task automatic t_chroma_gain();
    `CHK(gain_o, CGAIN_UNITY)
    wb(1'b1, EVEN_LOOP_OFS, 8'h40);
    field(8'h80);
    `CHK(gain_o >= CGAIN_MIN && gain_o <= CGAIN_MAX && gain_o !== CGAIN_UNITY, 1'b1)
    wb(1'b1, EVEN_LOOP_OFS, 8'h00);
    step(3); `CHK(gain_o, CGAIN_UNITY)
  endtask

  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0;
    wdat = 32'h00000000; odd_field = 1'b0; field_end = 1'b0; pix_valid = 1'b0;
    luma = 8'h00; chroma_level = 8'h40; base_agc = 8'h10; luma_decimation_control = 1'b0;
    step(2);
    rst_n <= 1'b1;
    step(1);
    t_reset_vals();
    t_field_copies();
    t_filters();
    t_white_crush();
    t_chroma_gain();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    step(20000);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
